//--- shared/dbs_pkg.sv
// Constants and carrier types for the burst-of-two DDR SRAM access port.
// Function
// - Write data is sampled at both input clock rising edges, K and K-bar.
// - Read data launches a new word at each K and K-bar rising edge.
// - Data outputs float whenever no read word is being driven.
// - Each address picks one word in each of two equal arrays.
// - Load strobe sampled at K rise; low starts a new bus cycle.
// - Every transaction moves exactly two words on consecutive edges.
// - With load low, direction high means read and low means write.
// - Address is shared by reads and writes and sampled at K rise.
// - Eight-bit mode: select zero gates bits 3:0, select one bits 7:4.
// - Nibble selects are sampled on the same edge as their data word.
// - A deasserted nibble select leaves that stored nibble unchanged.
// - Nine-bit lanes: each byte select gates one nine-bit lane in order.
// - Byte selects sampled with their word; deasserted lane stays unchanged.
// - A valid indicator is asserted while read data on the outputs is valid.
// - The valid indicator changes on the same edges as the echo clocks.
// - Accesses start and controls are captured on the K rising edge.
// - Echo clocks run continuously outside reset, locked to the positive input clock.
// - PLL disable held low selects the single-cycle latency mode.
package dbs_pkg;
   localparam int DBS_DATA_W = 36;
   localparam int DBS_ADDR_W = 20;
   localparam int DBS_NIB_W = 4;
   localparam int DBS_LANE_W = 9;
   localparam int DBS_BURST = 2;
   localparam int DBS_LAT_PLL = 2;
   localparam int DBS_LAT_DLL = 1;
   localparam int DBS_DLL_FMAX_MHZ = 167;
   localparam int DBS_SYNC_N = 3;

   // Status that crosses from the link domain into the system domain.
   typedef struct packed {
      logic rd_tog;
      logic wr_tog;
      logic up;
   } dbs_xing_t;

   // Single-bit pins launched as double data rate pairs.
   typedef struct packed {
      logic valid;
      logic oe_n;
      logic echo;
      logic echo_n;
   } dbs_ddr_t;
endpackage

//--- rtl/dbs_port.sv
// Burst-of-two DDR SRAM access port with its status crossing.
`timescale 1ns/1ps

// ==========================================================
// Level synchroniser: a change counts once stages two and three agree.
module dbs_sync #(
   parameter int W = 1
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   import dbs_pkg::*;
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   always_ff @(posedge clk_in) begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q_out <= '0;
      end else begin
         q_out <= (s2_reg & s3_reg) | (q_out & (s2_reg | s3_reg));
      end
   end
endmodule // dbs_sync

// ==========================================================
// Device-side port; link_clk_in is K, its falling edge stands for K-bar.
module dbs_port #(
   parameter int DATA_W = dbs_pkg::DBS_DATA_W,
   parameter int ADDR_W = dbs_pkg::DBS_ADDR_W,
   parameter int SEL_W = (DATA_W == 8) ? 2 : DATA_W / dbs_pkg::DBS_LANE_W,
   parameter int LAT_PLL = dbs_pkg::DBS_LAT_PLL,
   parameter int LAT_DLL = dbs_pkg::DBS_LAT_DLL
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic link_clk_in,
   input wire logic load_strobe_n_in,
   input wire logic rd_wr_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [SEL_W-1:0] write_sel_n_in,
   input wire logic pll_disable_n_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n_out,
   output logic read_out_valid_out,
   output logic echo_strobe_out,
   output logic echo_strobe_n_out,
   output logic read_cmd_seen_out,
   output logic write_cmd_seen_out,
   output logic link_up_out
);
   import dbs_pkg::*;

   localparam int LANE_W = (DATA_W == 8) ? DBS_NIB_W : DBS_LANE_W;
   localparam int LAT_MAX = (LAT_PLL > LAT_DLL) ? LAT_PLL : LAT_DLL;
   localparam int PIPE = LAT_MAX + 1;
   localparam int LP1 = LAT_PLL + 1;
   localparam int LD1 = LAT_DLL + 1;
   localparam int DEPTH = 1 << ADDR_W;

   // ==========================================================
   // Elaboration checks.
   if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)) begin : g_bad_w
      $error("dbs_port: DATA_W must be 8, 9, 18 or 36");
   end
   if (SEL_W * LANE_W != DATA_W) begin : g_bad_sel
      $error("dbs_port: SEL_W does not cover DATA_W");
   end
   if (LAT_PLL < 1 || LAT_DLL < 1 || ADDR_W < 1) begin : g_bad_lat
      $error("dbs_port: latencies and ADDR_W must be at least one");
   end

   // ==========================================================
   // Reset and mode strap into the link domain.
   logic [1:0] lsync_q;
   logic link_rst;
   logic dll_mode;

   dbs_sync #(.W(2)) u_link_sync (
      .clk_in(link_clk_in),
      .rst_in(1'b0),
      .d_in({sys_rst_in, pll_disable_n_in}),
      .q_out(lsync_q)
   );
   assign link_rst = lsync_q[1];
   assign dll_mode = ~lsync_q[0];

   // ==========================================================
   // Command capture on the K rising edge.
   logic wr_pend_reg;
   logic wr_act_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   logic [ADDR_W-1:0] wr_act_addr_reg;
   logic [PIPE-1:0] rd_pipe_reg;
   logic [ADDR_W-1:0] raddr_pipe_reg [PIPE];
   logic rd_load;
   logic wr_load;

   // A high load strobe starts nothing, so address and direction are ignored.
   assign rd_load = ~load_strobe_n_in & rd_wr_in;
   assign wr_load = ~load_strobe_n_in & ~rd_wr_in;

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         wr_pend_reg <= 1'b0;
         wr_act_reg <= 1'b0;
         rd_pipe_reg <= '0;
      end else begin
         wr_pend_reg <= wr_load;
         wr_act_reg <= wr_pend_reg;
         rd_pipe_reg <= {rd_pipe_reg[PIPE-2:0], rd_load};
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         wr_addr_reg <= '0;
         wr_act_addr_reg <= '0;
      end else begin
         if (wr_load) begin
            wr_addr_reg <= addr_in;
         end
         wr_act_addr_reg <= wr_addr_reg;
      end
   end

   always_ff @(posedge link_clk_in) begin
      raddr_pipe_reg[0] <= addr_in;
      for (int k = 1; k < PIPE; k++) begin
         raddr_pipe_reg[k] <= raddr_pipe_reg[k-1];
      end
   end

   // ==========================================================
   // Two equal arrays, one per word of the burst.
   logic [DATA_W-1:0] mem0 [DEPTH];
   logic [DATA_W-1:0] mem1 [DEPTH];

   // First word lands one cycle after the load, on the K rising edge.
   always_ff @(posedge link_clk_in) begin
      if (wr_pend_reg) begin
         for (int i = 0; i < SEL_W; i++) begin
            if (!write_sel_n_in[i]) begin
               mem0[wr_addr_reg][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // Second word lands on the following K-bar rising edge.
   always_ff @(negedge link_clk_in) begin
      if (wr_act_reg) begin
         for (int i = 0; i < SEL_W; i++) begin
            if (!write_sel_n_in[i]) begin
               mem1[wr_act_addr_reg][i*LANE_W +: LANE_W] <= dq_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ==========================================================
   // Read launch after the latency of the current mode.
   logic go;
   logic [ADDR_W-1:0] go_addr;
   logic launch_p_reg;
   logic [ADDR_W-1:0] launch_addr_reg;

   assign go = dll_mode ? rd_pipe_reg[LAT_DLL-1] : rd_pipe_reg[LAT_PLL-1];
   assign go_addr = dll_mode ? raddr_pipe_reg[LAT_DLL-1] : raddr_pipe_reg[LAT_PLL-1];

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         launch_p_reg <= 1'b0;
         launch_addr_reg <= '0;
      end else begin
         launch_p_reg <= go;
         launch_addr_reg <= go_addr;
      end
   end

   // ==========================================================
   // Double data rate outputs.
   // Each pin is the XOR of a rising-edge and a falling-edge flop, so it
   // changes exactly at each edge without a clock-driven multiplexer.
   logic [DATA_W-1:0] dqp_reg;
   logic [DATA_W-1:0] dqn_reg;
   dbs_ddr_t ctlp_reg;
   dbs_ddr_t ctln_reg;
   dbs_ddr_t ctl_val_p;
   dbs_ddr_t ctl_val_n;
   dbs_ddr_t ctl_pin;
   // Pins float and the echo pair rests apart in reset, so nothing is driven early.
   localparam dbs_ddr_t CTL_IDLE = '{valid: 1'b0, oe_n: 1'b1, echo: 1'b0, echo_n: 1'b1};

   assign ctl_val_p = '{valid: go, oe_n: ~go, echo: 1'b1, echo_n: 1'b0};
   assign ctl_val_n = '{valid: launch_p_reg, oe_n: ~launch_p_reg, echo: 1'b0, echo_n: 1'b1};

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         dqp_reg <= '0;
         ctlp_reg <= CTL_IDLE;
      end else begin
         dqp_reg <= (go ? mem0[go_addr] : '0) ^ dqn_reg;
         ctlp_reg <= ctl_val_p ^ ctln_reg;
      end
   end

   always_ff @(negedge link_clk_in) begin
      if (link_rst) begin
         dqn_reg <= '0;
         ctln_reg <= '0;
      end else begin
         dqn_reg <= (launch_p_reg ? mem1[launch_addr_reg] : '0) ^ dqp_reg;
         ctln_reg <= ctl_val_n ^ ctlp_reg;
      end
   end

   assign ctl_pin = ctlp_reg ^ ctln_reg;
   assign dq_out = dqp_reg ^ dqn_reg;
   assign dq_oe_n_out = ctl_pin.oe_n;
   assign read_out_valid_out = ctl_pin.valid;
   assign echo_strobe_out = ctl_pin.echo;
   assign echo_strobe_n_out = ctl_pin.echo_n;

   // ==========================================================
   // Status crossing into the system clock domain.
   dbs_xing_t xing_reg;
   dbs_xing_t xing_q;
   dbs_xing_t xing_last_reg;

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         xing_reg <= '0;
      end else begin
         xing_reg.rd_tog <= xing_reg.rd_tog ^ rd_load;
         xing_reg.wr_tog <= xing_reg.wr_tog ^ wr_load;
         xing_reg.up <= 1'b1;
      end
   end

   dbs_sync #(.W($bits(dbs_xing_t))) u_sys_sync (
      .clk_in(clk_in),
      .rst_in(sys_rst_in),
      .d_in(xing_reg),
      .q_out(xing_q)
   );

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         xing_last_reg <= '0;
         read_cmd_seen_out <= 1'b0;
         write_cmd_seen_out <= 1'b0;
         link_up_out <= 1'b0;
      end else begin
         xing_last_reg <= xing_q;
         read_cmd_seen_out <= xing_q.rd_tog ^ xing_last_reg.rd_tog;
         write_cmd_seen_out <= xing_q.wr_tog ^ xing_last_reg.wr_tog;
         link_up_out <= xing_q.up;
      end
   end

   // ==========================================================
   // Assertions.
   // The link reset is unknown until its filter fills, so system reset mutes these too.
   sequence s_rd_load;
      !load_strobe_n_in && rd_wr_in;
   endsequence

   sequence s_wr_load;
      !load_strobe_n_in && !rd_wr_in;
   endsequence

   sequence s_drive;
      !dq_oe_n_out && read_out_valid_out;
   endsequence

   property p_rd_pll;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         (!dll_mode && !load_strobe_n_in && rd_wr_in) |-> ##LP1 s_drive;
   endproperty
   a_rd_pll: assert property (p_rd_pll) else $error("read word missing in PLL mode");

   property p_rd_dll;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         (dll_mode && !load_strobe_n_in && rd_wr_in) |-> ##LD1 s_drive;
   endproperty
   a_rd_dll: assert property (p_rd_dll) else $error("read word missing in DLL mode");

   property p_tri;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         !launch_p_reg |-> dq_oe_n_out;
   endproperty
   a_tri: assert property (p_tri) else $error("data driven without read");

   property p_valid;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         read_out_valid_out != dq_oe_n_out;
   endproperty
   a_valid: assert property (p_valid) else $error("valid disagrees with drive");

   property p_wr_seq;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         s_wr_load |=> wr_pend_reg ##1 wr_act_reg;
   endproperty
   a_wr_seq: assert property (p_wr_seq) else $error("write burst not two words");

   property p_wr_addr;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         s_wr_load |=> (wr_addr_reg == $past(addr_in));
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("write address not captured");

   property p_echo_lo;
      @(posedge link_clk_in) disable iff (link_rst || sys_rst_in)
         !echo_strobe_out && echo_strobe_n_out;
   endproperty
   a_echo_lo: assert property (p_echo_lo) else $error("echo wrong before K rise");

   property p_echo_hi;
      @(negedge link_clk_in) disable iff (link_rst || sys_rst_in)
         $past(!link_rst) |-> echo_strobe_out && !echo_strobe_n_out;
   endproperty
   a_echo_hi: assert property (p_echo_hi) else $error("echo wrong before K fall");

   property p_seen;
      @(posedge clk_in) disable iff (sys_rst_in)
         read_cmd_seen_out |=> !read_cmd_seen_out;
   endproperty
   a_seen: assert property (p_seen) else $error("read seen pulse too long");
endmodule // dbs_port

//--- bench/dbs_host_model.sv
// Host controller model that drives the link-side inputs of the port.
`timescale 1ns/1ps
// ==========================================================
// Host request driver.
module dbs_host_model #(
   parameter int AW = 6
) (
   input wire logic k_in,
   output logic load_n_out,
   output logic rd_wr_out,
   output logic [AW-1:0] addr_out,
   output logic [35:0] dq_out,
   output logic [3:0] sel_n_out
);
   initial begin
      load_n_out = 1'b1;
      rd_wr_out = 1'b0;
      addr_out = '0;
      dq_out = 36'h5a5a5a5a5;
      sel_n_out = 4'hf;
   end
   // Call just after a K rise; the load is taken at the next K rise.
   task automatic cmd(input logic rw, input logic [AW-1:0] a, input logic [35:0] w0,
         input logic [35:0] w1, input logic [3:0] s0, input logic [3:0] s1, input bit last);
      load_n_out <= 1'b0;
      rd_wr_out <= rw;
      addr_out <= a;
      @(posedge k_in);
      if (last) begin
         // A stray address with load high must be ignored by the port.
         load_n_out <= 1'b1;
         addr_out <= ~a;
      end
      if (!rw) begin
         dq_out <= w0;
         sel_n_out <= s0;
         @(posedge k_in);
         dq_out <= w1;
         sel_n_out <= s1;
         @(posedge k_in);
         // The inverse makes a stale word on the released bus visible.
         dq_out <= ~w1;
         sel_n_out <= 4'hf;
      end
   endtask
endmodule // dbs_host_model

//--- bench/dbs_port_tb.sv
// Self-checking bench for the burst-of-two DDR SRAM port.
`timescale 1ns/1ps
// ==========================================================
// Bench top.
module dbs_port_tb;
   import dbs_pkg::*;
   localparam int AW = 6;
   localparam logic [35:0] A0 = 36'h123456789;
   localparam logic [35:0] A1 = 36'hfedcba987;
   logic clk_in = 1'b0;
   logic k = 1'b0;
   logic sys_rst_in = 1'b1;
   logic pll_n = 1'b1;
   logic load_n, rw, oe_n, vld, echo, echo_n, rd_seen, wr_seen, up;
   logic [AW-1:0] addr;
   logic [35:0] dqi, dqo;
   logic [3:0] sel_n;
   int fails = 0;
   int cmp_count = 0;
   int rd_cnt = 0;
   int wr_cnt = 0;
   always #12.5 clk_in = ~clk_in;
   initial begin
      #7;
      forever #40 k = ~k;
   end
   dbs_port #(.ADDR_W(AW)) u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .link_clk_in(k), .load_strobe_n_in(load_n), .rd_wr_in(rw), .addr_in(addr),
      .dq_in(dqi), .write_sel_n_in(sel_n), .pll_disable_n_in(pll_n), .dq_out(dqo),
      .dq_oe_n_out(oe_n), .read_out_valid_out(vld), .echo_strobe_out(echo),
      .echo_strobe_n_out(echo_n), .read_cmd_seen_out(rd_seen),
      .write_cmd_seen_out(wr_seen), .link_up_out(up));
   dbs_host_model #(.AW(AW)) u_host (.k_in(k), .load_n_out(load_n), .rd_wr_out(rw),
      .addr_out(addr), .dq_out(dqi), .sel_n_out(sel_n));
   always @(posedge clk_in) begin
      if (rd_seen === 1'b1)
         rd_cnt <= rd_cnt + 1;
      if (wr_seen === 1'b1)
         wr_cnt <= wr_cnt + 1;
   end
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
         input logic [3:0] s);
      merge = o;
      for (int i = 0; i < 4; i++)
         if (!s[i])
            merge[i*DBS_LANE_W +: DBS_LANE_W] = n[i*DBS_LANE_W +: DBS_LANE_W];
   endfunction
   task automatic do_reset();
      @(posedge clk_in);
      sys_rst_in <= 1'b1;
      repeat (15) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      repeat (6) @(posedge k);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [35:0] w0, input logic [35:0] w1,
         input logic [3:0] s0, input logic [3:0] s1);
      u_host.cmd(1'b0, a, w0, w1, s0, s1, 1'b1);
   endtask
   task automatic pair(input logic [35:0] e0, input logic [35:0] e1);
      #1;
      chk("oe_n", 36'h0, 36'(oe_n));
      chk("valid", 36'h1, 36'(vld));
      chk("word0", e0, dqo);
      @(negedge k);
      #1;
      chk("word1", e1, dqo);
      chk("valid1", 36'h1, 36'(vld));
      @(posedge k);
   endtask
   task automatic idle_chk();
      #1;
      chk("oe_n idle", 36'h1, 36'(oe_n));
      chk("valid idle", 36'h0, 36'(vld));
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [35:0] e0, input logic [35:0] e1,
         input int lat);
      u_host.cmd(1'b1, a, '0, '0, 4'hf, 4'hf, 1'b1);
      repeat (lat) @(posedge k);
      pair(e0, e1);
      idle_chk();
   endtask
   task automatic t_basic();
      wr(6'h3, A0, A1, 4'h0, 4'h0);
      rd(6'h3, A0, A1, DBS_LAT_PLL);
   endtask
   task automatic t_masks();
      wr(6'h5, '1, '1, 4'h0, 4'h0);
      wr(6'h5, '0, '0, 4'ha, 4'h5);
      rd(6'h5, merge('1, '0, 4'ha), merge('1, '0, 4'h5), DBS_LAT_PLL);
   endtask
   task automatic t_b2b();
      wr(6'h6, ~A0, ~A1, 4'h0, 4'h0);
      u_host.cmd(1'b1, 6'h3, '0, '0, 4'hf, 4'hf, 1'b0);
      u_host.cmd(1'b1, 6'h6, '0, '0, 4'hf, 4'hf, 1'b1);
      @(posedge k);
      pair(A0, A1);
      pair(~A0, ~A1);
      idle_chk();
   endtask
   task automatic t_echo();
      repeat (3) begin
         @(posedge k);
         #1;
         chk("echo rise", 36'h1, 36'(echo));
         chk("echo_n rise", 36'h0, 36'(echo_n));
         @(negedge k);
         #1;
         chk("echo fall", 36'h0, 36'(echo));
         chk("echo_n fall", 36'h1, 36'(echo_n));
      end
   endtask
   task automatic t_status();
      repeat (20) @(posedge clk_in);
      chk("read loads", 36'd4, 36'(rd_cnt));
      chk("write loads", 36'd4, 36'(wr_cnt));
      chk("link up", 36'h1, 36'(up));
   endtask
   task automatic t_dll();
      @(posedge clk_in);
      pll_n <= 1'b0;
      do_reset();
      rd(6'h3, A0, A1, DBS_LAT_DLL);
   endtask
   task automatic print_verdict();
      if (fails == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      do_reset();
      t_basic();
      t_masks();
      t_b2b();
      t_echo();
      t_status();
      t_dll();
      print_verdict();
   end
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule // dbs_port_tb
